// File: include/nvmpc_defs.svh
// Offsets, field positions, reset values and timing counts of the NVM control block
`ifndef NVMPC_DEFS_SVH
`define NVMPC_DEFS_SVH
`define NVMPC_CTRL_OFS 14'h0007
`define NVMPC_OPT_OFS 14'h0100
`define NVMPC_MOR_OFS 14'h3DFE
`define NVMPC_CTRL_RST 8'h00
`define NVMPC_B_ELAT 5
`define NVMPC_B_EPGM 4
`define NVMPC_B_ECLK 3
`define NVMPC_B_ERA 2
`define NVMPC_B_LAT 1
`define NVMPC_B_PUMP 0
`define NVMPC_B_PROT 1
`define NVMPC_B_SEC 0
`define NVMPC_B_POR_DELAY_SELECT 4
`define NVMPC_B_WATCHDOG_AFTER_RESET 3
`define NVMPC_B_WATCHDOG_IN_WAIT 2
`define NVMPC_B_PORTB_PULLDOWN_OPTION 1
`define NVMPC_B_PORTC_PULLDOWN_OPTION 0
`define NVMPC_POR_SHORT 12'h010
`define NVMPC_POR_LONG 12'hFE0
`define NVMPC_EE_UPPER 14'h0120
`define NVMPC_EE_LAST 14'h01FF
`endif

// File: include/nvmpc_pkg.sv
// Types of the NVM control block
package nvmpc_pkg;
  typedef enum logic [1:0]
  {
    NVMPC_ST_READ = 2'b00,
    NVMPC_ST_LOAD = 2'b10,
    NVMPC_ST_PROG = 2'b11
  } nvmpc_eprom_st_t;
endpackage

// File: rtl/nvmpc_ctrl.sv
// NVM program/erase control with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "nvmpc_defs.svh"
module nvmpc_ctrl #(
  parameter int ADDR_W = 14,
  parameter int NBYTES = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [7:0] writedata,
  output logic [7:0] readdata,
  output logic waitrequest,
  input wire logic stop_entry,
  input wire logic wait_mode,
  input wire logic bootstrap_mode,
  input wire logic [ADDR_W-1:0] eprom_addr,
  input wire logic eprom_wr,
  input wire logic [7:0] eprom_wdata,
  input wire logic [7:0] eprom_rdata_raw,
  output logic [7:0] eprom_rdata,
  input wire logic [ADDR_W-1:0] eeprom_addr,
  input wire logic eeprom_wr,
  input wire logic [7:0] eeprom_wdata,
  input wire logic [7:0] factory_options_in,
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portc_dir,
  output logic [7:0] portb_pulldown,
  output logic [7:0] portc_pulldown,
  output logic [ADDR_W-1:0] eprom_prog_addr,
  output logic [NBYTES*8-1:0] eprom_prog_data,
  output logic [NBYTES-1:0] eprom_prog_mask,
  output logic eprom_prog_active,
  output logic [ADDR_W-1:0] eeprom_prog_addr,
  output logic [7:0] eeprom_prog_data,
  output logic eeprom_prog_active,
  output logic eeprom_erase_active,
  output logic eeprom_charge_pump_on,
  output logic por_release,
  output logic watchdog_enable,
  output logic security_lock
);
  logic eprom_latch_enable_ff;
  logic eprom_program_enable_ff;
  logic eclk_ff;
  logic eeprom_erase_select_ff;
  logic eeprom_latch_enable_ff;
  logic eeprom_pump_ff;
  logic eprom_loaded_ff;
  logic eeprom_loaded_ff;
  logic eeprom_blocked_ff;
  logic [ADDR_W-1:0] ep_addr_ff;
  logic [NBYTES*8-1:0] ep_data_ff;
  logic [NBYTES-1:0] ep_mask_ff;
  logic [ADDR_W-1:0] ee_addr_ff;
  logic [7:0] ee_data_ff;
  logic [7:0] opt_ff;
  logic [7:0] mor_ff;
  logic por_started_ff;
  logic [11:0] por_cnt_ff;
  logic por_release_ff;
  logic wd_after_ff;
  logic security_ff;
  logic wait_ff;
  logic [7:0] rdata_ff;
  logic [7:0] eprom_rdata_ff;
  logic [7:0] pdb_ff;
  logic [7:0] pdc_ff;
  logic wd_en_ff;
  logic sel_ctrl;
  logic sel_opt;
  logic sel_mor;
  logic ctrl_wr;
  logic ep_capture;
  logic ee_capture;
  logic ee_upper;
  logic protect_active;
  logic [7:0] nxt_rdata;
  nvmpc_pkg::nvmpc_eprom_st_t ep_state;

  assign sel_ctrl = (address == `NVMPC_CTRL_OFS);
  assign sel_opt = (address == `NVMPC_OPT_OFS);
  assign sel_mor = (address == `NVMPC_MOR_OFS);
  // Writes act only at the accept edge, when waitrequest is low
  assign ctrl_wr = write && !waitrequest && sel_ctrl;
  assign ep_state = nvmpc_pkg::nvmpc_eprom_st_t'({eprom_latch_enable_ff,
                                                  eprom_program_enable_ff});
  // Capture only in load state; page must match the first byte's page
  assign ep_capture = eprom_wr && (ep_state == nvmpc_pkg::NVMPC_ST_LOAD)
                      && (!eprom_loaded_ff
                          || eprom_addr[ADDR_W-1:3] == ep_addr_ff[ADDR_W-1:3]);
  assign ee_capture = eeprom_wr && eeprom_latch_enable_ff && !eeprom_pump_ff;
  assign ee_upper = (eeprom_addr >= `NVMPC_EE_UPPER) && (eeprom_addr <= `NVMPC_EE_LAST);
  // Protect bit is sampled live; bootstrap overrides it
  assign protect_active = !opt_ff[`NVMPC_B_PROT] && !bootstrap_mode;

  // One wait state on every access keeps read data registered
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wait_ff <= 1'b1;
    else
      wait_ff <= !((read || write) && wait_ff);
  end
  assign waitrequest = wait_ff;

  always_comb
  begin
    nxt_rdata = 8'h00;
    if (sel_ctrl)
      nxt_rdata = {2'b00, eprom_latch_enable_ff, eprom_program_enable_ff, eclk_ff,
                   eeprom_erase_select_ff, eeprom_latch_enable_ff, eeprom_pump_ff};
    else if (sel_opt)
      nxt_rdata = {6'h00, opt_ff[1:0]};
    else if (sel_mor)
      nxt_rdata = {3'h0, mor_ff[4:0]};
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_ff <= 8'h00;
    else if (read && wait_ff)
      rdata_ff <= nxt_rdata;
  end
  assign readdata = rdata_ff;

  // EPROM latch-enable and program-enable pair
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eprom_latch_enable_ff <= 1'b0;
      eprom_program_enable_ff <= 1'b0;
    end
    else if (stop_entry)
    begin
      eprom_latch_enable_ff <= 1'b0;
      eprom_program_enable_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      eprom_latch_enable_ff <= writedata[`NVMPC_B_ELAT];
      if (!writedata[`NVMPC_B_ELAT])
        eprom_program_enable_ff <= 1'b0;
      else if (writedata[`NVMPC_B_EPGM] && eprom_latch_enable_ff && eprom_loaded_ff)
        eprom_program_enable_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      eclk_ff <= 1'b0;
    else if (ctrl_wr)
      eclk_ff <= writedata[`NVMPC_B_ECLK];
  end

  // EPROM programming latches, one byte lane per low address
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eprom_loaded_ff <= 1'b0;
      ep_addr_ff <= '0;
    end
    else if (!eprom_latch_enable_ff)
      eprom_loaded_ff <= 1'b0;
    else if (ep_capture)
    begin
      eprom_loaded_ff <= 1'b1;
      ep_addr_ff <= eprom_addr;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++)
    begin : g_lane
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          ep_data_ff[gi*8 +: 8] <= 8'h00;
          ep_mask_ff[gi] <= 1'b0;
        end
        else if (!eprom_latch_enable_ff)
          ep_mask_ff[gi] <= 1'b0;
        else if (ep_capture && eprom_addr[2:0] == 3'(gi))
        begin
          ep_data_ff[gi*8 +: 8] <= eprom_wdata;
          ep_mask_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Garbage while latched: reads show the array data inverted, not the latch image
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      eprom_rdata_ff <= 8'h00;
    else if (eprom_latch_enable_ff)
      eprom_rdata_ff <= ~eprom_rdata_raw;
    else
      eprom_rdata_ff <= eprom_rdata_raw;
  end

  // EEPROM erase-select, latch and pump
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eeprom_latch_enable_ff <= 1'b0;
      eeprom_erase_select_ff <= 1'b0;
      eeprom_pump_ff <= 1'b0;
    end
    else if (stop_entry || (ctrl_wr && !writedata[`NVMPC_B_LAT]))
    begin
      eeprom_latch_enable_ff <= 1'b0;
      eeprom_erase_select_ff <= 1'b0;
      eeprom_pump_ff <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      eeprom_latch_enable_ff <= 1'b1;
      if (!eeprom_loaded_ff)
        eeprom_erase_select_ff <= writedata[`NVMPC_B_ERA];
      if (writedata[`NVMPC_B_PUMP] && eeprom_latch_enable_ff && eeprom_loaded_ff)
        eeprom_pump_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eeprom_loaded_ff <= 1'b0;
      eeprom_blocked_ff <= 1'b0;
      ee_addr_ff <= '0;
      ee_data_ff <= 8'h00;
    end
    else if (!eeprom_latch_enable_ff)
    begin
      eeprom_loaded_ff <= 1'b0;
      eeprom_blocked_ff <= 1'b0;
    end
    else if (ee_capture)
    begin
      eeprom_loaded_ff <= 1'b1;
      eeprom_blocked_ff <= ee_upper && protect_active;
      ee_addr_ff <= eeprom_addr;
      ee_data_ff <= eeprom_wdata;
    end
  end

  // Option image: array is outside, this holds the live copy
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      opt_ff <= 8'h00;
    else if (!por_started_ff)
      opt_ff <= 8'h00;
    // Latched byte acts while the pump runs; programming only clears bits
    else if (eeprom_prog_active && ee_addr_ff == `NVMPC_OPT_OFS)
      opt_ff[1:0] <= opt_ff[1:0] & ee_data_ff[1:0];
    else if (eeprom_erase_active && ee_addr_ff == `NVMPC_OPT_OFS)
      opt_ff[1:0] <= 2'b11;
  end

  // Strap capture on the first clock after nrst rises; options then frozen until next reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      por_started_ff <= 1'b0;
      mor_ff <= 8'h00;
      wd_after_ff <= 1'b0;
      security_ff <= 1'b0;
    end
    else if (!por_started_ff)
    begin
      por_started_ff <= 1'b1;
      mor_ff <= factory_options_in;
      wd_after_ff <= factory_options_in[`NVMPC_B_WATCHDOG_AFTER_RESET] && !bootstrap_mode;
      security_ff <= 1'b0;
    end
    else if (!por_release_ff)
      security_ff <= 1'b0;
  end

  // Reset pin hold count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      por_cnt_ff <= 12'h000;
      por_release_ff <= 1'b0;
    end
    else if (por_started_ff && !por_release_ff)
    begin
      por_cnt_ff <= por_cnt_ff + 12'h001;
      if (por_cnt_ff + 12'h001 >= (mor_ff[`NVMPC_B_POR_DELAY_SELECT] ? `NVMPC_POR_SHORT
                                                          : `NVMPC_POR_LONG))
        por_release_ff <= 1'b1;
    end
  end

  // Security-latched flag: set to one at strap capture, cleared only by reset
  logic sec_latched_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sec_latched_ff <= 1'b0;
    else if (!por_started_ff)
      sec_latched_ff <= 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wd_en_ff <= 1'b0;
      pdb_ff <= 8'h00;
      pdc_ff <= 8'h00;
    end
    else
    begin
      wd_en_ff <= wd_after_ff && (!wait_mode || mor_ff[`NVMPC_B_WATCHDOG_IN_WAIT]);
      pdb_ff <= mor_ff[`NVMPC_B_PORTB_PULLDOWN_OPTION] ? ~portb_dir : 8'h00;
      pdc_ff <= mor_ff[`NVMPC_B_PORTC_PULLDOWN_OPTION] ? ~portc_dir : 8'h00;
    end
  end

  // Lock is the inverted bit from strap capture until reset release, then holds: the next reset clears the live copy, so a bit changed in run is lost
  logic lock_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      lock_ff <= 1'b1;
    else if (por_started_ff && !sec_latched_ff)
      lock_ff <= 1'b1;
    else if (!por_release_ff && por_started_ff)
      lock_ff <= !factory_sec_in(opt_ff);
  end

  function automatic logic factory_sec_in(input logic [7:0] o);
    factory_sec_in = o[`NVMPC_B_SEC];
  endfunction

  assign eprom_rdata = eprom_rdata_ff;
  assign portb_pulldown = pdb_ff;
  assign portc_pulldown = pdc_ff;
  assign eprom_prog_addr = ep_addr_ff;
  assign eprom_prog_data = ep_data_ff;
  assign eprom_prog_mask = ep_mask_ff;
  assign eprom_prog_active = eprom_program_enable_ff;
  assign eeprom_prog_addr = ee_addr_ff;
  assign eeprom_prog_data = ee_data_ff;
  // Blocked upper-region access: pump bit stands but nothing reaches the array
  assign eeprom_prog_active = eeprom_pump_ff && !eeprom_erase_select_ff
                              && !eeprom_blocked_ff;
  assign eeprom_erase_active = eeprom_pump_ff && eeprom_erase_select_ff
                               && !eeprom_blocked_ff;
  assign eeprom_charge_pump_on = eeprom_pump_ff;
  assign por_release = por_release_ff;
  assign watchdog_enable = wd_en_ff;
  assign security_lock = lock_ff;
endmodule
`default_nettype wire

// File: sim/nvmpc_monitor.sv
// Port-level checker for the NVM program/erase control block
`timescale 1ns/10ps
`default_nettype none
module nvmpc_monitor #(
  parameter int NBYTES = 8
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic stop_entry,
  input wire logic wait_mode,
  input wire logic [7:0] factory_options_in,
  input wire logic [7:0] portb_dir,
  input wire logic [7:0] portb_pulldown,
  input wire logic [NBYTES-1:0] eprom_prog_mask,
  input wire logic eprom_prog_active,
  input wire logic eeprom_prog_active,
  input wire logic eeprom_erase_active,
  input wire logic eeprom_charge_pump_on,
  input wire logic por_release,
  input wire logic watchdog_enable,
  input wire logic security_lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_wait;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_stop;
    stop_entry |-> ##[1:2] !eprom_prog_active && !eeprom_charge_pump_on;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left a latch set");
  property p_mask;
    eprom_prog_mask == '0 |-> !eprom_prog_active;
  endproperty
  a_mask: assert property (p_mask) else $error("program without byte");
  property p_pump;
    eeprom_prog_active || eeprom_erase_active |->
      eeprom_charge_pump_on && !(eeprom_prog_active && eeprom_erase_active);
  endproperty
  a_pump: assert property (p_pump) else $error("bad eeprom state");
  property p_por;
    por_release |=> por_release;
  endproperty
  a_por: assert property (p_por) else $error("reset release dropped");
  property p_sec;
    por_release |=> $stable(security_lock);
  endproperty
  a_sec: assert property (p_sec) else $error("security changed in run");
  property p_pd;
    por_release && $stable(portb_dir) |->
      portb_pulldown == (~portb_dir & {8{factory_options_in[1]}});
  endproperty
  a_pd: assert property (p_pd) else $error("pulldown wrong");
  property p_wdw;
    wait_mode && $past(wait_mode) && $past(wait_mode, 2) && !factory_options_in[2]
      |-> !watchdog_enable;
  endproperty
  a_wdw: assert property (p_wdw) else $error("watchdog on in wait");
  c_eprom: cover property (eprom_prog_active);
  c_erase: cover property (eeprom_erase_active);
  c_por: cover property ($rose(por_release));
endmodule
bind nvmpc_ctrl nvmpc_monitor #(.NBYTES(NBYTES)) u_mon (.clk(clk), .nrst(nrst), .read(read),
  .write(write), .waitrequest(waitrequest), .stop_entry(stop_entry), .wait_mode(wait_mode),
  .factory_options_in(factory_options_in), .portb_dir(portb_dir),
  .portb_pulldown(portb_pulldown), .eprom_prog_mask(eprom_prog_mask),
  .eprom_prog_active(eprom_prog_active), .eeprom_prog_active(eeprom_prog_active),
  .eeprom_erase_active(eeprom_erase_active), .eeprom_charge_pump_on(eeprom_charge_pump_on),
  .por_release(por_release), .watchdog_enable(watchdog_enable),
  .security_lock(security_lock));
`default_nettype wire

// File: sim/nvmpc_tb.sv
// Self-checking testbench of the NVM program/erase control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, stop_entry = 1'b0;
  logic wait_mode = 1'b0, bootstrap_mode = 1'b0, eprom_wr = 1'b0, eeprom_wr = 1'b0;
  logic waitrequest, eprom_prog_active, eeprom_prog_active, eeprom_erase_active;
  logic eeprom_charge_pump_on, por_release, watchdog_enable, security_lock;
  logic [13:0] address = 14'h0000, eprom_addr = 14'h0000, eeprom_addr = 14'h0000;
  logic [13:0] eprom_prog_addr, eeprom_prog_addr;
  logic [7:0] writedata = 8'h00, eprom_wdata = 8'h00, eeprom_wdata = 8'h00;
  logic [7:0] eprom_rdata_raw = 8'h3C, factory_options_in = 8'h1A;
  logic [7:0] portb_dir = 8'hF0, portc_dir = 8'h0F;
  logic [7:0] readdata, eprom_rdata, portb_pulldown, portc_pulldown, eeprom_prog_data, q;
  logic [7:0] eprom_prog_mask;
  logic [63:0] eprom_prog_data;
  int errors = 0;
  int comparisons = 0;
  int n;
  always #5 clk = ~clk;
  nvmpc_ctrl DUT (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .stop_entry(stop_entry), .wait_mode(wait_mode), .bootstrap_mode(bootstrap_mode),
    .eprom_addr(eprom_addr), .eprom_wr(eprom_wr), .eprom_wdata(eprom_wdata),
    .eprom_rdata_raw(eprom_rdata_raw), .eprom_rdata(eprom_rdata), .eeprom_addr(eeprom_addr),
    .eeprom_wr(eeprom_wr), .eeprom_wdata(eeprom_wdata),
    .factory_options_in(factory_options_in), .portb_dir(portb_dir), .portc_dir(portc_dir),
    .portb_pulldown(portb_pulldown), .portc_pulldown(portc_pulldown),
    .eprom_prog_addr(eprom_prog_addr), .eprom_prog_data(eprom_prog_data),
    .eprom_prog_mask(eprom_prog_mask), .eprom_prog_active(eprom_prog_active),
    .eeprom_prog_addr(eeprom_prog_addr), .eeprom_prog_data(eeprom_prog_data),
    .eeprom_prog_active(eeprom_prog_active), .eeprom_erase_active(eeprom_erase_active),
    .eeprom_charge_pump_on(eeprom_charge_pump_on), .por_release(por_release),
    .watchdog_enable(watchdog_enable), .security_lock(security_lock));
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    #1;
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task settle;
    repeat (2) @(posedge clk);
  endtask
  // Count is taken from release; a couple of edges of slack for the sampling stage
  task rst(input logic [7:0] opt, input int exp);
    @(posedge clk);
    nrst <= 1'b0;
    factory_options_in <= opt;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    while (por_release !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    comparisons++;
    if (n < exp || n > exp + 2)
    begin
      errors++;
      $display("CHECK FAILED %0t reset release after %0d", $time, n);
    end
  endtask
  task bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task rd(input logic [13:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task ctl(input logic [7:0] d, input logic [7:0] e);
    bus(1'b1, 14'h0007, d);
    rd(14'h0007, e);
  endtask
  // Kind 0 EPROM write, 1 EEPROM write, 2 STOP entry
  task pulse(input int k, input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    if (k == 0)
    begin
      eprom_addr <= a;
      eprom_wdata <= d;
      eprom_wr <= 1'b1;
    end
    else if (k == 1)
    begin
      eeprom_addr <= a;
      eeprom_wdata <= d;
      eeprom_wr <= 1'b1;
    end
    else
      stop_entry <= 1'b1;
    @(posedge clk);
    eprom_wr <= 1'b0;
    eeprom_wr <= 1'b0;
    stop_entry <= 1'b0;
  endtask
  initial
  begin
    #200000;
    errors++;
    give_verdict;
  end
  initial
  begin
    rst(8'h1A, 16);
    rd(14'h0007, 8'h00);
    rd(14'h0050, 8'h00);
    chk({portb_pulldown, portc_pulldown, 7'h00, watchdog_enable}, 24'h0F0001);
    // Long enough in WAIT for the checker's three-sample window
    @(posedge clk);
    wait_mode <= 1'b1;
    repeat (4) @(posedge clk);
    chk(watchdog_enable, 1'b0);
    @(posedge clk);
    wait_mode <= 1'b0;
    ctl(8'h10, 8'h00);
    ctl(8'h20, 8'h20);
    ctl(8'h30, 8'h20);
    chk(eprom_rdata, 8'hC3);
    pulse(0, 14'h1005, 8'hA5);
    pulse(0, 14'h1010, 8'h77);
    pulse(0, 14'h1000, 8'h5C);
    settle;
    chk({eprom_prog_mask, eprom_prog_data[47:40], eprom_prog_data[7:0]}, 24'h21A55C);
    chk(eprom_prog_addr[13:3], 11'h200);
    ctl(8'h30, 8'h30);
    chk(eprom_prog_active, 1'b1);
    ctl(8'h20, 8'h30);
    ctl(8'h00, 8'h00);
    chk({eprom_prog_active, eprom_rdata}, 9'h03C);
    ctl(8'h22, 8'h22);
    pulse(0, 14'h1003, 8'h01);
    ctl(8'h32, 8'h32);
    pulse(2, 14'h0000, 8'h00);
    rd(14'h0007, 8'h00);
    ctl(8'h05, 8'h00);
    ctl(8'h02, 8'h02);
    ctl(8'h03, 8'h02);
    pulse(1, 14'h0105, 8'h5A);
    ctl(8'h06, 8'h02);
    ctl(8'h03, 8'h03);
    chk({eeprom_prog_active, eeprom_erase_active, eeprom_prog_addr, eeprom_prog_data},
      24'h81055A);
    ctl(8'h02, 8'h03);
    ctl(8'h00, 8'h00);
    ctl(8'h06, 8'h06);
    pulse(1, 14'h0110, 8'hFF);
    ctl(8'h03, 8'h07);
    chk({eeprom_prog_active, eeprom_erase_active}, 2'b01);
    ctl(8'h00, 8'h00);
    // Erase the option byte, then program only the protect bit back to zero
    ctl(8'h06, 8'h06);
    pulse(1, 14'h0100, 8'hFF);
    ctl(8'h07, 8'h07);
    ctl(8'h00, 8'h00);
    rd(14'h0100, 8'h03);
    chk(security_lock, 1'b1);
    ctl(8'h02, 8'h02);
    pulse(1, 14'h0100, 8'hFD);
    ctl(8'h03, 8'h03);
    ctl(8'h00, 8'h00);
    rd(14'h0100, 8'h01);
    // Same upper-region attempt with and without bootstrap mode
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk);
      bootstrap_mode <= b[0];
      ctl(8'h02, 8'h02);
      pulse(1, 14'h0130, 8'h11);
      bus(1'b1, 14'h0007, 8'h03);
      settle;
      chk(eeprom_prog_active, b[0]);
      ctl(8'h00, 8'h00);
    end
    @(posedge clk);
    bootstrap_mode <= 1'b0;
    rst(8'h05, 4064);
    settle;
    chk({portb_pulldown, portc_pulldown, 6'h00, watchdog_enable, security_lock},
      24'h00F001);
    // Bootstrap at release keeps the watchdog off; wait option keeps it running
    @(posedge clk);
    bootstrap_mode <= 1'b1;
    rst(8'h1C, 16);
    chk(watchdog_enable, 1'b0);
    @(posedge clk);
    bootstrap_mode <= 1'b0;
    rst(8'h1C, 16);
    @(posedge clk);
    wait_mode <= 1'b1;
    repeat (4) @(posedge clk);
    chk(watchdog_enable, 1'b1);
    @(posedge clk);
    wait_mode <= 1'b0;
    give_verdict;
  end
endmodule
`default_nettype wire
